// ===== common/tmr_pkg.sv
// Behaviour
// (RQ1) clock select zero stops the counter
// (RQ2) counter readable and writable at any time
// (RQ3) software counter write beats count operations
// (RQ4) each tick clears, increments or decrements counter
// (RQ5) bidirectional counter with top and bottom indications
// (RQ6) bottom is zero, max is 255
// (RQ7) top is max or compare A
// (RQ8) counter and compare registers are eight bits
// (RQ9) three flags readable, each gated by mask
// (RQ10) tick from prescaler or external pin edge
// (RQ11) equality sets compare flag one tick later
// (RQ12) flags clear on service or writing one
// (RQ13) overflow flag set per mode, can interrupt
// (RQ14) three-bit mode split over control A and B
// (RQ15) PWM modes buffer compare writes until top/bottom
// (RQ16) normal and CTC modes write compare directly
// (RQ17) force strobe updates output, no flag, no clear
// (RQ18) counter write blocks next tick's matches
// (RQ19) outputs formed from match, mode, output mode
// (RQ20) output state kept across modes, output mode immediate
// (RQ21) software sets output before pin; no bottom while down
// (RQ22) timer enabled when power reduce bit is zero
// (RQ23) mode zero counts up, wraps, overflow at zero
// (RQ24) mode two clears on compare A match
// (RQ25) modes three and seven are fast PWM
// (RQ26) output mode zero leaves output state unchanged
// (RQ27) tick is one-cycle enable, pin synchronised
package tmr_pkg;
   localparam logic [3:0]  OFS_COUNT   = 4'h0;
   localparam logic [3:0]  OFS_CMP_A   = 4'h1;
   localparam logic [3:0]  OFS_CMP_B   = 4'h2;
   localparam logic [3:0]  OFS_CTRL_A  = 4'h3;
   localparam logic [3:0]  OFS_CTRL_B  = 4'h4;
   localparam logic [3:0]  OFS_CTRL_C  = 4'h5;
   localparam logic [3:0]  OFS_FLAG    = 4'h6;
   localparam logic [3:0]  OFS_MASK    = 4'h7;
   localparam logic [3:0]  OFS_POWER   = 4'h8;
   localparam logic [7:0]  CNT_BOTTOM  = 8'h00;
   localparam logic [7:0]  CNT_MAX     = 8'hFF;
   localparam logic [2:0]  WGM_NORMAL  = 3'h0;
   localparam logic [2:0]  WGM_PC_MAX  = 3'h1;
   localparam logic [2:0]  WGM_CTC     = 3'h2;
   localparam logic [2:0]  WGM_FAST    = 3'h3;
   localparam logic [2:0]  WGM_PC_A    = 3'h5;
   localparam logic [2:0]  WGM_FAST_A  = 3'h7;
   localparam logic [2:0]  CS_STOP     = 3'h0;
   localparam logic [2:0]  CS_EXT_FALL = 3'h6;
   localparam logic [2:0]  CS_EXT_RISE = 3'h7;
   localparam logic [1:0]  FLG_OVF     = 2'd0;
   localparam logic [1:0]  FLG_CMPA    = 2'd1;
   localparam logic [1:0]  FLG_CMPB    = 2'd2;
   localparam logic [7:0]  RST_BYTE    = 8'h00;
   localparam logic [31:0] BUS_ZERO    = 32'h0000_0000;

   typedef struct packed {
      logic [1:0] com_a;
      logic [1:0] com_b;
      logic [1:0] wgm_lo;
      logic       wgm_hi;
      logic [2:0] cs;
   } tmr_ctrl_t;

   // (RQ8) eight-bit counter and compares
   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] ocr_a;
      logic [7:0] ocr_b;
      logic [7:0] buf_a;
      logic [7:0] buf_b;
      tmr_ctrl_t  ctl;
      logic [2:0] flag;
      logic [2:0] mask;
      logic       prr;
      logic       down;
      logic       block;
      logic       oc_a;
      logic       oc_b;
      logic [1:0] ext_sync;
      logic       ext_old;
      logic       ack;
      logic [31:0] rdat;
   } tmr_state_t;
endpackage

// ===== core/tmr_core.sv
`timescale 1ns/1ps
module tmr_core
   import tmr_pkg::*;
(
   input  wire logic        MCLK,        // system clock, 40 MHz
   input  wire logic        SRST,        // synchronous reset, active high
   input  wire logic        CYC_I,       // wishbone cycle
   input  wire logic        STB_I,       // wishbone strobe
   input  wire logic        WE_I,        // wishbone write enable
   input  wire logic [5:2]  ADR_I,       // word address
   input  wire logic [3:0]  SEL_I,       // byte selects
   input  wire logic [31:0] DAT_I,       // write data
   output logic      [31:0] DAT_O,       // read data
   output logic             ACK_O,       // wishbone acknowledge
   input  wire logic        PRESC_TICK,  // one-cycle prescaler tick
   input  wire logic        EXT_COUNT,   // external count input pin
   output logic             WAVE_OUT_A,  // compare output state a
   output logic             WAVE_OUT_B,  // compare output state b
   output logic             IRQ_OVF,     // overflow request
   output logic             IRQ_CMPA,    // compare a request
   output logic             IRQ_CMPB,    // compare b request
   input  wire logic        IRQ_ACK_OVF, // overflow request serviced
   input  wire logic        IRQ_ACK_CMPA,// compare a request serviced
   input  wire logic        IRQ_ACK_CMPB // compare b request serviced
);
   tmr_state_t s_ff, nxt_s;

   logic [2:0] wgm;
   logic       pwm;
   logic       fast;
   logic       dual;
   logic [7:0] top_val;
   logic       tick;
   logic       req;
   logic       wr;
   logic       wr_b0;
   logic       at_top;
   logic       at_bot;
   logic       m_a;
   logic       m_b;
   logic       ext_rise;
   logic       ext_fall;
   logic [7:0] wb;

   // (RQ14) mode assembled from both controls
   assign wgm     = {s_ff.ctl.wgm_hi, s_ff.ctl.wgm_lo};
   assign fast    = (wgm == WGM_FAST) || (wgm == WGM_FAST_A);
   assign dual    = (wgm == WGM_PC_MAX) || (wgm == WGM_PC_A);
   assign pwm     = fast || dual;
   // (RQ7) top from max or compare a
   assign top_val = (wgm == WGM_CTC || wgm == WGM_FAST_A || wgm == WGM_PC_A) ? s_ff.ocr_a : CNT_MAX;
   // (RQ5) top and bottom indications
   assign at_top  = s_ff.cnt == top_val;
   // (RQ6) bottom is zero
   assign at_bot  = s_ff.cnt == CNT_BOTTOM;
   assign ext_rise = s_ff.ext_sync[1] & ~s_ff.ext_old;
   assign ext_fall = ~s_ff.ext_sync[1] & s_ff.ext_old;

   // (RQ10) (RQ27) (RQ1) (RQ22) tick source and enable
   always_comb begin
      case (s_ff.ctl.cs)
         CS_STOP:     tick = 1'b0;
         CS_EXT_FALL: tick = ext_fall;
         CS_EXT_RISE: tick = ext_rise;
         default:     tick = PRESC_TICK;
      endcase
      if (s_ff.prr) begin
         tick = 1'b0;
      end
   end

   // (RQ11) continuous compare, blocked after counter write
   assign m_a = tick && !s_ff.block && (s_ff.cnt == s_ff.ocr_a);
   assign m_b = tick && !s_ff.block && (s_ff.cnt == s_ff.ocr_b);

   assign req   = CYC_I && STB_I && !s_ff.ack;
   assign wr    = req && WE_I;
   assign wr_b0 = wr && SEL_I[0];
   assign wb    = DAT_I[7:0];

   always_comb begin
      nxt_s = s_ff;
      nxt_s.ack = req;
      nxt_s.ext_sync = {s_ff.ext_sync[0], EXT_COUNT};
      nxt_s.ext_old  = s_ff.ext_sync[1];

      // (RQ4) counter advance per mode
      if (tick) begin
         nxt_s.block = 1'b0;
         if (dual) begin
            if (!s_ff.down) begin
               if (at_top) begin
                  nxt_s.down = 1'b1;
                  nxt_s.cnt  = s_ff.cnt - 8'h01;
               end else begin
                  nxt_s.cnt  = s_ff.cnt + 8'h01;
               end
            end else if (at_bot) begin
               nxt_s.down = 1'b0;
               nxt_s.cnt  = s_ff.cnt + 8'h01;
            end else begin
               nxt_s.cnt  = s_ff.cnt - 8'h01;
            end
         // (RQ24) (RQ25) clear at top in ctc and fast
         end else if ((wgm == WGM_CTC || fast) && at_top) begin
            nxt_s.cnt = CNT_BOTTOM;
         end else begin
            // (RQ23) plain upward count with wrap
            nxt_s.cnt  = s_ff.cnt + 8'h01;
            nxt_s.down = 1'b0;
         end
      end

      // (RQ13) (RQ23) overflow point per mode
      if (tick && ((!dual && s_ff.cnt == CNT_MAX && !(wgm == WGM_CTC && at_top))
                   || (fast && at_top) || (dual && s_ff.down && at_bot))) begin
         nxt_s.flag[FLG_OVF] = 1'b1;
      end
      if (tick && wgm == WGM_CTC && at_top && s_ff.cnt == CNT_MAX) begin
         nxt_s.flag[FLG_OVF] = 1'b1;
      end

      // (RQ15) buffered compare update at top in both fast and dual slope
      if (tick && ((fast && at_top) || (dual && at_top && !s_ff.down))) begin
         nxt_s.ocr_a = s_ff.buf_a;
         nxt_s.ocr_b = s_ff.buf_b;
      end

      // (RQ19) (RQ26) waveform from match and output mode
      if (m_a && s_ff.ctl.com_a != 2'b00) begin
         if (!pwm) begin
            case (s_ff.ctl.com_a)
               2'b01:   nxt_s.oc_a = ~s_ff.oc_a;
               2'b10:   nxt_s.oc_a = 1'b0;
               default: nxt_s.oc_a = 1'b1;
            endcase
         end else if (s_ff.ctl.com_a[1]) begin
            nxt_s.oc_a = dual ? (s_ff.ctl.com_a[0] ^ s_ff.down) : s_ff.ctl.com_a[0];
         end
      end
      if (m_b && s_ff.ctl.com_b != 2'b00) begin
         if (!pwm) begin
            case (s_ff.ctl.com_b)
               2'b01:   nxt_s.oc_b = ~s_ff.oc_b;
               2'b10:   nxt_s.oc_b = 1'b0;
               default: nxt_s.oc_b = 1'b1;
            endcase
         end else if (s_ff.ctl.com_b[1]) begin
            nxt_s.oc_b = dual ? (s_ff.ctl.com_b[0] ^ s_ff.down) : s_ff.ctl.com_b[0];
         end
      end
      // fast pwm restores the idle level at bottom
      if (tick && fast && at_top) begin
         if (s_ff.ctl.com_a[1]) nxt_s.oc_a = ~s_ff.ctl.com_a[0];
         if (s_ff.ctl.com_b[1]) nxt_s.oc_b = ~s_ff.ctl.com_b[0];
      end

      // (RQ12) serviced flags clear
      if (IRQ_ACK_OVF)  nxt_s.flag[FLG_OVF]  = 1'b0;
      if (IRQ_ACK_CMPA) nxt_s.flag[FLG_CMPA] = 1'b0;
      if (IRQ_ACK_CMPB) nxt_s.flag[FLG_CMPB] = 1'b0;

      if (wr_b0) begin
         case (ADR_I)
            OFS_COUNT: begin
               // (RQ3) (RQ2) (RQ18) write wins and blocks next match
               nxt_s.cnt   = wb;
               nxt_s.block = 1'b1;
            end
            // (RQ16) direct access outside pwm
            OFS_CMP_A: begin
               nxt_s.buf_a = wb;
               if (!pwm) nxt_s.ocr_a = wb;
            end
            OFS_CMP_B: begin
               nxt_s.buf_b = wb;
               if (!pwm) nxt_s.ocr_b = wb;
            end
            // (RQ20) output mode takes effect at once
            OFS_CTRL_A: begin
               nxt_s.ctl.com_a  = wb[7:6];
               nxt_s.ctl.com_b  = wb[5:4];
               nxt_s.ctl.wgm_lo = wb[1:0];
            end
            OFS_CTRL_B: begin
               nxt_s.ctl.wgm_hi = wb[3];
               nxt_s.ctl.cs     = wb[2:0];
            end
            // (RQ17) forced match without flag or clear
            OFS_CTRL_C: begin
               if (!pwm && wb[7]) begin
                  case (s_ff.ctl.com_a)
                     2'b01:   nxt_s.oc_a = ~s_ff.oc_a;
                     2'b10:   nxt_s.oc_a = 1'b0;
                     2'b11:   nxt_s.oc_a = 1'b1;
                     default: nxt_s.oc_a = s_ff.oc_a;
                  endcase
               end
               if (!pwm && wb[6]) begin
                  case (s_ff.ctl.com_b)
                     2'b01:   nxt_s.oc_b = ~s_ff.oc_b;
                     2'b10:   nxt_s.oc_b = 1'b0;
                     2'b11:   nxt_s.oc_b = 1'b1;
                     default: nxt_s.oc_b = s_ff.oc_b;
                  endcase
               end
            end
            // (RQ12) write one clears
            OFS_FLAG:  nxt_s.flag = s_ff.flag & ~wb[2:0];
            OFS_MASK:  nxt_s.mask = wb[2:0];
            OFS_POWER: nxt_s.prr  = wb[0];
            default: ;
         endcase
      end

      // (RQ11) match sets flag; set beats clear
      if (m_a) nxt_s.flag[FLG_CMPA] = 1'b1;
      if (m_b) nxt_s.flag[FLG_CMPB] = 1'b1;
      if (tick && ((!dual && s_ff.cnt == CNT_MAX) || (fast && at_top) || (dual && s_ff.down && at_bot))) begin
         nxt_s.flag[FLG_OVF] = 1'b1;
      end

      nxt_s.rdat = BUS_ZERO;
      if (req && !WE_I) begin
         case (ADR_I)
            OFS_COUNT:  nxt_s.rdat[7:0] = s_ff.cnt;
            OFS_CMP_A:  nxt_s.rdat[7:0] = pwm ? s_ff.buf_a : s_ff.ocr_a;
            OFS_CMP_B:  nxt_s.rdat[7:0] = pwm ? s_ff.buf_b : s_ff.ocr_b;
            OFS_CTRL_A: nxt_s.rdat[7:0] = {s_ff.ctl.com_a, s_ff.ctl.com_b, 2'b00, s_ff.ctl.wgm_lo};
            OFS_CTRL_B: nxt_s.rdat[7:0] = {4'h0, s_ff.ctl.wgm_hi, s_ff.ctl.cs};
            OFS_FLAG:   nxt_s.rdat[7:0] = {5'h00, s_ff.flag};
            OFS_MASK:   nxt_s.rdat[7:0] = {5'h00, s_ff.mask};
            OFS_POWER:  nxt_s.rdat[7:0] = {7'h00, s_ff.prr};
            default:    nxt_s.rdat = BUS_ZERO;
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign DAT_O      = s_ff.rdat;
   assign ACK_O      = s_ff.ack;
   assign WAVE_OUT_A = s_ff.oc_a;
   assign WAVE_OUT_B = s_ff.oc_b;
   // (RQ9) masked requests
   assign IRQ_OVF    = s_ff.flag[FLG_OVF]  & s_ff.mask[FLG_OVF];
   assign IRQ_CMPA   = s_ff.flag[FLG_CMPA] & s_ff.mask[FLG_CMPA];
   assign IRQ_CMPB   = s_ff.flag[FLG_CMPB] & s_ff.mask[FLG_CMPB];

   // (RQ1) stopped counter holds
   stop_hold_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ1
      (s_ff.ctl.cs == CS_STOP && !$past(wr_b0) ##0 !wr_b0) |=> $stable(s_ff.cnt) or $past(wr_b0))
      else $error("counter moved while stopped");
   // (RQ3) write wins
   cnt_write_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ3
      (wr_b0 && ADR_I == OFS_COUNT) |=> s_ff.cnt == $past(wb))
      else $error("counter write lost");
   // (RQ11) flag after match
   match_flag_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ11
      m_a |=> s_ff.flag[FLG_CMPA])
      else $error("compare a flag not set");
   // (RQ18) block after write
   write_block_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ18
      (wr_b0 && ADR_I == OFS_COUNT) |=> !m_a && !m_b)
      else $error("match not blocked");
   // (RQ9) mask gates request
   irq_mask_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ9
      (m_a && !wr) |=> IRQ_CMPA == s_ff.mask[FLG_CMPA])
      else $error("compare a request not per mask");
   // (RQ23) wrap and overflow
   wrap_ovf_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ23
      (tick && wgm == WGM_NORMAL && s_ff.cnt == CNT_MAX && !wr_b0) |=> s_ff.cnt == CNT_BOTTOM && s_ff.flag[FLG_OVF])
      else $error("normal wrap wrong");
   // (RQ24) ctc clear
   ctc_clear_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ24
      (tick && wgm == WGM_CTC && at_top && !wr) |=> s_ff.cnt == CNT_BOTTOM)
      else $error("ctc did not clear");
   // (RQ26) output mode zero holds
   com_zero_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ26
      (s_ff.ctl.com_a == 2'b00 && !wr) |=> $stable(s_ff.oc_a))
      else $error("output a moved with mode zero");
   // (RQ22) power reduce stops ticks
   power_off_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ22
      (s_ff.prr && !wr) |=> $stable(s_ff.cnt))
      else $error("counter moved while power reduced");
   // (RQ12) service clears flag
   svc_clear_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ12
      (IRQ_ACK_CMPA && !m_a) |=> !s_ff.flag[FLG_CMPA])
      else $error("serviced compare a flag stayed");
   // (RQ12) write one clears
   wr_clear_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ12
      (wr_b0 && ADR_I == OFS_FLAG && DAT_I[FLG_CMPA] && !m_a) |=> !s_ff.flag[FLG_CMPA])
      else $error("written compare a flag stayed");
   // (RQ11) compare b flag
   flag_b_set_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ11
      m_b |=> s_ff.flag[FLG_CMPB])
      else $error("compare b flag not set");
   // (RQ13) fast pwm overflow
   fast_ovf_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ13
      (tick && wgm == WGM_FAST && s_ff.cnt == CNT_MAX) |=> s_ff.flag[FLG_OVF])
      else $error("fast overflow flag not set");
   // (RQ15) buffered compare holds
   buf_hold_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ15
      (pwm && !tick) |=> $stable(s_ff.ocr_a))
      else $error("active compare moved between ticks");
   // (RQ16) direct compare write
   direct_cmp_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ16
      (wr_b0 && ADR_I == OFS_CMP_B && !pwm) |=> s_ff.ocr_b == $past(wb))
      else $error("direct compare write lost");
   // (RQ17) force keeps counter
   force_cnt_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ17
      (wr_b0 && ADR_I == OFS_CTRL_C && !tick) |=> $stable(s_ff.cnt))
      else $error("force moved the counter");
   // (RQ17) force sets no flag
   force_flag_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ17
      (wr_b0 && ADR_I == OFS_CTRL_C && !m_a && !s_ff.flag[FLG_CMPA]) |=> !s_ff.flag[FLG_CMPA])
      else $error("force set a flag");
   // (RQ19) toggle on match
   toggle_out_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ19
      (m_a && !pwm && s_ff.ctl.com_a == 2'b01 && !wr) |=> s_ff.oc_a != $past(s_ff.oc_a))
      else $error("output a did not toggle");
   // (RQ20) mode change keeps output
   mode_keep_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ20
      (wr_b0 && ADR_I == OFS_CTRL_A && !m_a && !tick) |=> $stable(s_ff.oc_a))
      else $error("mode write moved output a");
   // (RQ4) normal mode increments
   up_count_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ4
      (tick && wgm == WGM_NORMAL && !wr) |=> s_ff.cnt == $past(s_ff.cnt) + 8'h01)
      else $error("normal count did not increment");
   // (RQ5) dual slope decrements
   down_count_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ5
      (tick && dual && s_ff.down && !at_bot && !wr) |=> s_ff.cnt == $past(s_ff.cnt) - 8'h01)
      else $error("down count did not decrement");
   // (RQ6) turn at bottom
   bottom_turn_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ6
      (tick && dual && s_ff.down && at_bot && !wr) |=> s_ff.cnt == 8'h01 && !s_ff.down)
      else $error("no turn at bottom");
   // (RQ25) fast top clears
   fast_top_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ25
      (tick && wgm == WGM_FAST_A && at_top && !wr) |=> s_ff.cnt == CNT_BOTTOM)
      else $error("fast pwm did not clear at top");
   // (RQ18) block kept until tick
   block_hold_a: assert property (@(posedge MCLK) disable iff (SRST) // RQ18
      (s_ff.block && !tick) |=> s_ff.block)
      else $error("match block lost before tick");
endmodule

// ===== test/tmr_core_tb.sv
`timescale 1ns/1ps
module tmr_core_tb
   import tmr_pkg::*;
   ;
   typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;} tmr_row_t;
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic        tick = 1'b0;
   logic        ext = 1'b0;
   logic        svc = 1'b0;
   logic        cyc, stb, we, ack, wa, wb;
   logic [3:0]  adr, sel;
   logic [31:0] wdat, rdat;
   logic [2:0]  irq, iack;
   logic [7:0]  q;
   int          errors = 0;
   int          n_checks = 0;
   tmr_row_t    rows [8] = '{'{OFS_COUNT, 8'h3C, 8'h3C}, '{OFS_CMP_A, 8'h5A, 8'h5A},
      '{OFS_CMP_B, 8'hA5, 8'hA5}, '{OFS_CTRL_A, 8'hF0, 8'hF0}, '{OFS_MASK, 8'hFF, 8'h07},
      '{OFS_POWER, 8'h01, 8'h01}, '{OFS_POWER, 8'h00, 8'h00}, '{4'h9, 8'hFF, 8'h00}};
   always #12.5 mclk = ~mclk;
   tmr_core tmr_core_inst (.MCLK(mclk), .SRST(srst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
      .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .PRESC_TICK(tick), .EXT_COUNT(ext),
      .WAVE_OUT_A(wa), .WAVE_OUT_B(wb), .IRQ_OVF(irq[0]), .IRQ_CMPA(irq[1]), .IRQ_CMPB(irq[2]),
      .IRQ_ACK_OVF(iack[0]), .IRQ_ACK_CMPA(iack[1]), .IRQ_ACK_CMPB(iack[2]));
   tmr_host tmr_host_inst (.clk(mclk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
      .wdat(wdat), .rdat(rdat), .ack(ack), .irq(irq), .irq_ack(iack), .svc_en(svc));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
      bit ok;
      tmr_host_inst.bus(w, a, s, d, q, ok);
      if (!ok) begin
         errors++;
         wrap_up();
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      xfer(1'b1, a, d, 4'h1);
   endtask
   task automatic rd(input logic [3:0] a);
      xfer(1'b0, a, 8'h00, 4'h1);
   endtask
   task automatic ticks(input int k);
      repeat (k) begin
         @(posedge mclk);
         tick <= 1'b1;
         @(posedge mclk);
         tick <= 1'b0;
      end
      @(posedge mclk);
   endtask
   task automatic pin(input logic v);
      @(posedge mclk);
      ext <= v;
      repeat (8) @(posedge mclk);
   endtask
   task automatic tend(input string s);
      $display("test %s ends", s);
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         check(q, rows[i].e);
      end
      tend("register rows");
      @(posedge mclk);
      srst <= 1'b1;
      @(posedge mclk);
      srst <= 1'b0;
      rd(OFS_CMP_A);
      check(q, RST_BYTE);
      check({3'h0, wa, wb, irq}, 8'h00);
      tend("reset");
      wr(OFS_COUNT, 8'h10);
      ticks(3);
      rd(OFS_COUNT);
      check(q, 8'h10);
      xfer(1'b1, OFS_COUNT, 8'h77, 4'h0);
      rd(OFS_COUNT);
      check(q, 8'h10);
      tend("stopped");
      wr(OFS_CMP_A, 8'h80);
      wr(OFS_CMP_B, 8'h90);
      wr(OFS_COUNT, 8'hFE);
      wr(OFS_CTRL_B, 8'h01);
      ticks(1);
      rd(OFS_COUNT);
      check(q, CNT_MAX);
      ticks(1);
      rd(OFS_COUNT);
      check(q, CNT_BOTTOM);
      rd(OFS_FLAG);
      check(q, 8'h01);
      check({5'h00, irq}, 8'h00);
      wr(OFS_FLAG, 8'h01);
      rd(OFS_FLAG);
      check(q, 8'h00);
      tend("overflow");
      wr(OFS_COUNT, 8'h7E);
      ticks(2);
      rd(OFS_FLAG);
      check(q, 8'h00);
      ticks(1);
      rd(OFS_FLAG);
      check(q, 8'h02);
      wr(OFS_MASK, 8'h07);
      check({5'h00, irq}, 8'h02);
      svc <= 1'b1;
      repeat (6) @(posedge mclk);
      rd(OFS_FLAG);
      check(q, 8'h00);
      svc <= 1'b0;
      wr(OFS_MASK, 8'h00);
      tend("compare flag");
      wr(OFS_COUNT, 8'h90);
      ticks(2);
      rd(OFS_FLAG);
      check(q, 8'h00);
      tend("blocking");
      wr(OFS_CTRL_A, 8'h50);
      wr(OFS_CTRL_C, 8'hC0);
      check({6'h00, wa, wb}, 8'h03);
      rd(OFS_FLAG);
      check(q, 8'h00);
      wr(OFS_CTRL_A, 8'h00);
      wr(OFS_CTRL_C, 8'hC0);
      check({6'h00, wa, wb}, 8'h03);
      tend("force");
      wr(OFS_CMP_A, 8'h03);
      wr(OFS_CTRL_A, 8'h02);
      wr(OFS_COUNT, 8'h00);
      ticks(4);
      rd(OFS_COUNT);
      check(q, 8'h00);
      rd(OFS_FLAG);
      check(q, 8'h02);
      check({7'h00, wa}, 8'h01);
      tend("clear on match");
      wr(OFS_FLAG, 8'h07);
      wr(OFS_CTRL_A, 8'h03);
      wr(OFS_COUNT, 8'h20);
      wr(OFS_CMP_B, 8'h22);
      ticks(3);
      rd(OFS_FLAG);
      check(q, 8'h00);
      rd(OFS_CMP_B);
      check(q, 8'h22);
      tend("buffered compare");
      wr(OFS_CTRL_A, 8'h00);
      wr(OFS_COUNT, 8'h40);
      wr(OFS_CTRL_B, 8'h07);
      pin(1'b1);
      pin(1'b0);
      rd(OFS_COUNT);
      check(q, 8'h41);
      wr(OFS_CTRL_B, 8'h06);
      pin(1'b1);
      pin(1'b0);
      rd(OFS_COUNT);
      check(q, 8'h42);
      tend("external pin");
      wr(OFS_POWER, 8'h01);
      wr(OFS_CTRL_B, 8'h01);
      ticks(2);
      rd(OFS_COUNT);
      check(q, 8'h42);
      tend("power reduce");
      wr(OFS_POWER, 8'h00);
      wr(OFS_CTRL_A, 8'h01);
      wr(OFS_COUNT, 8'hFE);
      ticks(3);
      rd(OFS_COUNT);
      check(q, 8'hFD);
      tend("dual slope");
      wr(OFS_CTRL_A, 8'h03);
      wr(OFS_CTRL_B, 8'h09);
      wr(OFS_COUNT, 8'h02);
      ticks(2);
      rd(OFS_COUNT);
      check(q, CNT_BOTTOM);
      rd(OFS_FLAG);
      check(q, 8'h03);
      tend("fast top from compare a");
      wrap_up();
   end
endmodule

// ===== test/tmr_host.sv
`timescale 1ns/1ps
module tmr_host
   import tmr_pkg::*;
(
   input  wire logic        clk,     // system clock
   output logic             cyc,     // bus cycle
   output logic             stb,     // bus strobe
   output logic             we,      // write enable
   output logic [3:0]       adr,     // word index
   output logic [3:0]       sel,     // byte selects
   output logic [31:0]      wdat,    // write data
   input  wire logic [31:0] rdat,    // read data
   input  wire logic        ack,     // acknowledge
   input  wire logic [2:0]  irq,     // cmpb, cmpa, ovf requests
   output logic [2:0]       irq_ack, // service pulses
   input  wire logic        svc_en   // servicing on
);
   logic [1:0] cool;
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 4'hF;
      sel = 4'h0;
      wdat = BUS_ZERO;
      irq_ack = 3'h0;
      cool = 2'h0;
   end
   always @(posedge clk) begin
      irq_ack <= 3'h0;
      if (cool != 2'h0) begin
         cool <= cool - 2'h1;
      end else if (svc_en && irq != 3'h0) begin
         irq_ack <= irq;
         cool <= 2'h3;
      end
   end
   // counting turns down only in the dual slope test, and no counter write lands while it counts down
   task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [7:0] d,
                      output logic [7:0] q, output bit ok);
      ok = 1'b0;
      q = 8'h00;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= {24'h00_0000, d};
      // hold the request until the rising edge that samples ack high
      for (int n = 0; n < 20; n++) begin
         @(posedge clk);
         if (ack === 1'b1) begin
            ok = 1'b1;
            q = rdat[7:0];
            break;
         end
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= ~w;
      wdat <= ~{24'h00_0000, d};
   endtask
endmodule
